// file: verilog/drive_seq_pkg.sv
// Shared constants for the drive on/off sequencer
package drive_seq_pkg;

    // ************************************************
    // Sequencer states, one-hot
    // ************************************************
    typedef enum logic [5:0] {
        SWITCH_ON_INHIBITED_STATE   = 6'h01,
        READY_TO_SWITCH_ON_STATE    = 6'h02,
        READY_AWAITING_ENABLE_STATE = 6'h04,
        MOTOR_RUNNING_STATE         = 6'h08,
        NORMAL_STOP_STATE           = 6'h10,
        QUICK_STOP_STATE            = 6'h20
    } seq_state_t;

    // ************************************************
    // Register map (byte addresses, one word each)
    // ************************************************
    localparam logic [7:0] CTRL_ADDR        = 8'h00;
    localparam logic [7:0] RAMP_NORMAL_ADDR = 8'h04;
    localparam logic [7:0] RAMP_QUICK_ADDR  = 8'h08;
    localparam logic [7:0] STATUS_ADDR      = 8'h0C;
    localparam logic [7:0] SPEED_ADDR       = 8'h10;

    // Control register fields
    localparam int CTRL_ON_BIT       = 0;
    localparam int CTRL_COAST_BIT    = 1;
    localparam int CTRL_QUICK_BIT    = 2;
    localparam int CTRL_ENABLE_BIT   = 3;
    localparam int CTRL_FIELDBUS_BIT = 4;
    localparam int CTRL_WIDTH        = 5;

    // Status register fields
    localparam int STAT_STATE_LSB    = 0;
    localparam int STAT_MOTOR_BIT    = 6;
    localparam int STAT_STILL_BIT    = 7;

    // Reset values
    localparam logic [CTRL_WIDTH-1:0] CTRL_RESET = 5'h00;
    localparam logic [15:0] RAMP_NORMAL_RESET    = 16'h0010;
    localparam logic [15:0] RAMP_QUICK_RESET     = 16'h0004;

    // Speed model
    localparam int SPEED_W                  = 16;
    localparam logic [SPEED_W-1:0] SPEED_MAX = 16'h0100;
    localparam logic [SPEED_W-1:0] SPEED_ONE = 16'h0001;
    localparam logic [15:0] DIV_ONE          = 16'h0001;

endpackage : drive_seq_pkg

// file: verilog/speed_ramp.sv
// Speed ramp generator: one speed step every 'period' cycles
`timescale 1ns/1ps
module speed_ramp (
    input  wire logic                                clk,
    input  wire logic                                rst_n,
    input  wire logic                                energized,
    input  wire logic                                accel,
    input  wire logic [15:0]                         period,
    output logic      [drive_seq_pkg::SPEED_W-1:0]   speed_q,
    output logic                                     still_q
);
    logic [15:0] div_q;
    logic        tick;

    // ************************************************
    // Step prescaler
    // ************************************************
    assign tick = (div_q >= period) || (period == 16'h0000);

    always_ff @(posedge clk) begin
        if (!rst_n || tick || !energized) begin
            div_q <= drive_seq_pkg::DIV_ONE;
        end else begin
            div_q <= div_q + drive_seq_pkg::DIV_ONE;
        end
    end

    // Speed follows the ramp, drops at once when power is cut
    always_ff @(posedge clk) begin
        if (!rst_n || !energized) begin
            speed_q <= '0;
        end else if (tick) begin
            if (accel && speed_q != drive_seq_pkg::SPEED_MAX) begin
                speed_q <= speed_q + drive_seq_pkg::SPEED_ONE;
            end else if (!accel && speed_q != '0) begin
                speed_q <= speed_q - drive_seq_pkg::SPEED_ONE;
            end
        end
    end

    // Standstill flag
    always_ff @(posedge clk) begin
        if (!rst_n || !energized) begin
            still_q <= 1'b1;
        end else begin
            still_q <= (speed_q == '0) || (!accel && tick && speed_q == drive_seq_pkg::SPEED_ONE);
        end
    end
endmodule : speed_ramp

// file: verilog/drive_on_off_sequencer.sv
// Drive on/off sequencer with Wishbone register access
//
// Behaviour
// - Power-up enters ready-to-switch-on, awaits on
// - Switch-on energizes motor, enters running
// - Normal stop ramps down with normal time
// - Normal stop cuts power at standstill, ready
// - Coast stop cuts power immediately, no ramp
// - Quick stop ramps down with quick time
// - Quick stop cuts power only at standstill
// - On at power-up or coast/quick inhibits
// - Ready waits enable; default on without fieldbus
//
// The implementer's own choices: the register addresses and the Wishbone slave port.
`timescale 1ns/1ps
module drive_on_off_sequencer (
    input  wire logic        clk,
    input  wire logic        rst_n,
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [7:0]  wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output logic      [31:0] wb_dat_o,
    output logic             wb_ack_o,
    output logic             motor_on_q,
    output logic      [5:0]  state_q
);

    // ************************************************
    // Local widths
    // ************************************************
    localparam int RAMP_W  = 16;
    localparam int STATE_W = $bits(drive_seq_pkg::seq_state_t);

    // ************************************************
    // Helper functions
    // ************************************************

    // Address match for one word of the register map
    function automatic logic reg_hit(input logic [7:0] adr,
                                     input logic [7:0] base);
        reg_hit = (adr == base);
    endfunction : reg_hit

    // Byte-lane merge of a bus write into a 16-bit ramp register
    function automatic logic [15:0] lane_merge(input logic [15:0] old_val,
                                               input logic [31:0] wdat,
                                               input logic [3:0]  sel);
        lane_merge = old_val;
        if (sel[0]) begin
            lane_merge[7:0] = wdat[7:0];
        end
        if (sel[1]) begin
            lane_merge[15:8] = wdat[15:8];
        end
    endfunction : lane_merge

    // States in which the motor is energized
    function automatic logic is_energized(input drive_seq_pkg::seq_state_t s);
        is_energized = (s == drive_seq_pkg::MOTOR_RUNNING_STATE) ||
                       (s == drive_seq_pkg::NORMAL_STOP_STATE)   ||
                       (s == drive_seq_pkg::QUICK_STOP_STATE);
    endfunction : is_energized

    // ************************************************
    // Declarations
    // ************************************************
    logic                                  bus_req;
    logic                                  wr_en;
    logic                                  ack_q;
    logic [31:0]                           rdat_q;
    logic [31:0]                           rd_mux;
    logic [31:0]                           status_word;
    logic [drive_seq_pkg::CTRL_WIDTH-1:0]  ctrl_q;
    logic [RAMP_W-1:0]                     ramp_normal_q;
    logic [RAMP_W-1:0]                     ramp_quick_q;
    logic                                  on_cmd;
    logic                                  coast_cmd;
    logic                                  quick_cmd;
    logic                                  enable_eff;
    drive_seq_pkg::seq_state_t             seq_q;
    drive_seq_pkg::seq_state_t             seq_d;
    logic                                  accel;
    logic [RAMP_W-1:0]                     ramp_sel;
    logic [drive_seq_pkg::SPEED_W-1:0]     speed;
    logic                                  still;

    // ************************************************
    // Wishbone slave
    // ************************************************

    // A write lands only at the edge where ack is high
    assign bus_req = wb_cyc_i && wb_stb_i;
    assign wr_en   = bus_req && wb_we_i && ack_q;

    // Ack one cycle after the request, dropped the cycle after
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            ack_q <= 1'b0;
        end else begin
            ack_q <= bus_req && !ack_q;
        end
    end

    // Status word assembly
    always_comb begin
        status_word = '0;
        status_word[drive_seq_pkg::STAT_STATE_LSB +: STATE_W] = seq_q;
        status_word[drive_seq_pkg::STAT_MOTOR_BIT]            = motor_on_q;
        status_word[drive_seq_pkg::STAT_STILL_BIT]            = still;
    end

    // Read multiplexer, unmapped words read as zero
    always_comb begin
        rd_mux = '0;
        if (reg_hit(wb_adr_i, drive_seq_pkg::CTRL_ADDR)) begin
            rd_mux[drive_seq_pkg::CTRL_WIDTH-1:0] = ctrl_q;
        end else if (reg_hit(wb_adr_i, drive_seq_pkg::RAMP_NORMAL_ADDR)) begin
            rd_mux[RAMP_W-1:0] = ramp_normal_q;
        end else if (reg_hit(wb_adr_i, drive_seq_pkg::RAMP_QUICK_ADDR)) begin
            rd_mux[RAMP_W-1:0] = ramp_quick_q;
        end else if (reg_hit(wb_adr_i, drive_seq_pkg::STATUS_ADDR)) begin
            rd_mux = status_word;
        end else if (reg_hit(wb_adr_i, drive_seq_pkg::SPEED_ADDR)) begin
            rd_mux[drive_seq_pkg::SPEED_W-1:0] = speed;
        end
    end

    // Read data captured so it stands while ack is high
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            rdat_q <= '0;
        end else if (bus_req && !ack_q && !wb_we_i) begin
            rdat_q <= rd_mux;
        end
    end

    assign wb_ack_o = ack_q;
    assign wb_dat_o = rdat_q;

    // ************************************************
    // Command and ramp registers
    // ************************************************

    // Command word, low byte lane only
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            ctrl_q <= drive_seq_pkg::CTRL_RESET;
        end else if (wr_en && wb_sel_i[0] && reg_hit(wb_adr_i, drive_seq_pkg::CTRL_ADDR)) begin
            ctrl_q <= wb_dat_i[drive_seq_pkg::CTRL_WIDTH-1:0];
        end
    end

    // Normal ramp step period
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            ramp_normal_q <= drive_seq_pkg::RAMP_NORMAL_RESET;
        end else if (wr_en && reg_hit(wb_adr_i, drive_seq_pkg::RAMP_NORMAL_ADDR)) begin
            ramp_normal_q <= lane_merge(ramp_normal_q, wb_dat_i, wb_sel_i);
        end
    end

    // Quick-stop ramp step period
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            ramp_quick_q <= drive_seq_pkg::RAMP_QUICK_RESET;
        end else if (wr_en && reg_hit(wb_adr_i, drive_seq_pkg::RAMP_QUICK_ADDR)) begin
            ramp_quick_q <= lane_merge(ramp_quick_q, wb_dat_i, wb_sel_i);
        end
    end

    // Command decode
    assign on_cmd    = ctrl_q[drive_seq_pkg::CTRL_ON_BIT];
    assign coast_cmd = ctrl_q[drive_seq_pkg::CTRL_COAST_BIT];
    assign quick_cmd = ctrl_q[drive_seq_pkg::CTRL_QUICK_BIT];

    // Without fieldbus control the operating enable is always granted
    assign enable_eff = ctrl_q[drive_seq_pkg::CTRL_FIELDBUS_BIT] ?
                        ctrl_q[drive_seq_pkg::CTRL_ENABLE_BIT] : 1'b1;

    // ************************************************
    // Sequencer
    // ************************************************

    // Next state; coast first, then quick, then normal stop
    always_comb begin
        seq_d = seq_q;
        unique case (seq_q)
            drive_seq_pkg::SWITCH_ON_INHIBITED_STATE: begin
                // Stays while on or a stop is still asserted
                if (!on_cmd && !coast_cmd && !quick_cmd) begin
                    seq_d = drive_seq_pkg::READY_TO_SWITCH_ON_STATE;
                end
            end
            drive_seq_pkg::READY_TO_SWITCH_ON_STATE: begin
                if (coast_cmd || quick_cmd) begin
                    seq_d = drive_seq_pkg::SWITCH_ON_INHIBITED_STATE;
                end else if (on_cmd) begin
                    seq_d = drive_seq_pkg::READY_AWAITING_ENABLE_STATE;
                end
            end
            drive_seq_pkg::READY_AWAITING_ENABLE_STATE: begin
                if (coast_cmd || quick_cmd) begin
                    seq_d = drive_seq_pkg::SWITCH_ON_INHIBITED_STATE;
                end else if (!on_cmd) begin
                    seq_d = drive_seq_pkg::READY_TO_SWITCH_ON_STATE;
                end else if (enable_eff) begin
                    seq_d = drive_seq_pkg::MOTOR_RUNNING_STATE;
                end
            end
            drive_seq_pkg::MOTOR_RUNNING_STATE: begin
                if (coast_cmd) begin
                    seq_d = drive_seq_pkg::SWITCH_ON_INHIBITED_STATE;
                end else if (quick_cmd) begin
                    seq_d = drive_seq_pkg::QUICK_STOP_STATE;
                end else if (!on_cmd) begin
                    seq_d = drive_seq_pkg::NORMAL_STOP_STATE;
                end else if (!enable_eff) begin
                    seq_d = drive_seq_pkg::READY_AWAITING_ENABLE_STATE;
                end
            end
            drive_seq_pkg::NORMAL_STOP_STATE: begin
                if (coast_cmd) begin
                    seq_d = drive_seq_pkg::SWITCH_ON_INHIBITED_STATE;
                end else if (quick_cmd) begin
                    seq_d = drive_seq_pkg::QUICK_STOP_STATE;
                end else if (still) begin
                    seq_d = drive_seq_pkg::READY_TO_SWITCH_ON_STATE;
                end
            end
            drive_seq_pkg::QUICK_STOP_STATE: begin
                if (coast_cmd) begin
                    seq_d = drive_seq_pkg::SWITCH_ON_INHIBITED_STATE;
                end else if (still) begin
                    seq_d = drive_seq_pkg::SWITCH_ON_INHIBITED_STATE;
                end
            end
            default: begin
                // Illegal code falls back to the safe inhibited state
                seq_d = drive_seq_pkg::SWITCH_ON_INHIBITED_STATE;
            end
        endcase
    end

    // Command word resets to zero, so power-up lands in ready
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            seq_q <= drive_seq_pkg::READY_TO_SWITCH_ON_STATE;
        end else begin
            seq_q <= seq_d;
        end
    end

    // Motor power follows the next state, so it cuts at once
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            motor_on_q <= 1'b0;
        end else begin
            motor_on_q <= is_energized(seq_d);
        end
    end

    assign state_q = seq_q;

    // ************************************************
    // Speed ramp
    // ************************************************

    // Speed rises only while running; quick stop uses its own time
    assign accel    = (seq_q == drive_seq_pkg::MOTOR_RUNNING_STATE);
    assign ramp_sel = (seq_q == drive_seq_pkg::QUICK_STOP_STATE) ?
                      ramp_quick_q : ramp_normal_q;

    speed_ramp i_ramp (
        .clk       (clk),
        .rst_n     (rst_n),
        .energized (motor_on_q),
        .accel     (accel),
        .period    (ramp_sel),
        .speed_q   (speed),
        .still_q   (still)
    );

    // ************************************************
    // Assertions
    // ************************************************

    a_coast_cuts_power: assert property (
        @(posedge clk) disable iff (!rst_n)
        motor_on_q && coast_cmd |=> !motor_on_q
    ) else $error("coast stop left the motor energized");

    a_coast_beats_quick: assert property (
        @(posedge clk) disable iff (!rst_n)
        (seq_q == drive_seq_pkg::MOTOR_RUNNING_STATE) && coast_cmd && quick_cmd
        |=> (seq_q == drive_seq_pkg::SWITCH_ON_INHIBITED_STATE)
    ) else $error("coast stop did not take priority");

    a_quick_stop_entry: assert property (
        @(posedge clk) disable iff (!rst_n)
        (seq_q == drive_seq_pkg::MOTOR_RUNNING_STATE) && quick_cmd && !coast_cmd
        |=> (seq_q == drive_seq_pkg::QUICK_STOP_STATE)
    ) else $error("quick stop not entered from running");

    a_normal_waits_still: assert property (
        @(posedge clk) disable iff (!rst_n)
        (seq_q == drive_seq_pkg::NORMAL_STOP_STATE) && !still && !coast_cmd
        |=> motor_on_q
    ) else $error("normal stop cut power before standstill");

    a_quick_waits_still: assert property (
        @(posedge clk) disable iff (!rst_n)
        (seq_q == drive_seq_pkg::QUICK_STOP_STATE) && !still && !coast_cmd
        |=> (seq_q == drive_seq_pkg::QUICK_STOP_STATE) && motor_on_q
    ) else $error("quick stop left before standstill");

    a_inhibit_holds_on: assert property (
        @(posedge clk) disable iff (!rst_n)
        (seq_q == drive_seq_pkg::SWITCH_ON_INHIBITED_STATE) && on_cmd
        |=> (seq_q == drive_seq_pkg::SWITCH_ON_INHIBITED_STATE)
    ) else $error("switch-on accepted while inhibited");

    a_enable_gates_run: assert property (
        @(posedge clk) disable iff (!rst_n)
        (seq_q == drive_seq_pkg::READY_AWAITING_ENABLE_STATE) && !enable_eff
        |=> (seq_q != drive_seq_pkg::MOTOR_RUNNING_STATE)
    ) else $error("motor ran without operating enable");

endmodule : drive_on_off_sequencer

// file: dv/host_model.sv
// Host controller model issuing commands over Wishbone
`timescale 1ns/1ps
module host_model (
    input  wire logic        clk,
    input  wire logic        ack,
    input  wire logic [31:0] rdat,
    output logic             cyc,
    output logic             we,
    output logic      [7:0]  adr,
    output logic      [31:0] dat
);
    initial {cyc, we, adr, dat} = '0;
    // One classic cycle, held until ack, data scrambled after release
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                        output logic [31:0] q);
        cyc <= 1'b1;
        we  <= w;
        adr <= a;
        dat <= d;
        do @(posedge clk); while (ack !== 1'b1);
        q = rdat;
        cyc <= 1'b0;
        dat <= ~d;
        @(posedge clk);
    endtask : xfer
endmodule : host_model

// file: dv/drive_on_off_sequencer_tb.sv
// Self-checking bench for the drive on/off sequencer
`timescale 1ns/1ps
module drive_on_off_sequencer_tb;
    logic        clk, rst_n, cyc, we, ack, mot;
    logic [7:0]  adr;
    logic [31:0] dat, rdat, q;
    logic [5:0]  st;
    int          fail_count = 0, cmp_count = 0;
    drive_on_off_sequencer i_dut (.clk(clk), .rst_n(rst_n), .wb_cyc_i(cyc), .wb_stb_i(cyc),
        .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(dat), .wb_dat_o(rdat),
        .wb_ack_o(ack), .motor_on_q(mot), .state_q(st));
    host_model i_host (.clk(clk), .ack(ack), .rdat(rdat), .cyc(cyc), .we(we), .adr(adr),
        .dat(dat));
    // Compare one value seen against the value expected
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            fail_count++;
            $display("[ERR] %0t got %h want %h", $time, got, exp);
        end
        $display("test %0d done", cmp_count);
    endtask : check
    // Motor flag and state against expectation
    task automatic chk(input logic m, input logic [5:0] s);
        check({25'h0, mot, st}, {25'h0, m, s});
    endtask : chk
    // Register read against expectation
    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        i_host.xfer(1'b0, a, 32'h0000_0000, q);
        check(q, exp);
    endtask : rd
    task automatic test_done();
        $display("compares %0d mismatches %0d", cmp_count, fail_count);
        if (fail_count == 0 && cmp_count > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask : test_done
    // Write command word, then let it settle
    task automatic cmd(input logic [4:0] c, input int n);
        i_host.xfer(1'b1, drive_seq_pkg::CTRL_ADDR, {27'h0, c}, q);
        repeat (n) @(posedge clk);
    endtask : cmd
    // Bounded wait for the ramp to reach standstill
    task automatic leave();
        for (int i = 0; i < 20000 && st[5:4] !== 2'b00; i++) @(posedge clk);
    endtask : leave
    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end
    initial begin
        #400000;
        fail_count++;
        test_done();
    end
    initial begin
        rst_n = 1'b0;
        repeat (12) @(posedge clk);
        rst_n <= 1'b1;
        repeat (2) @(posedge clk);
        chk(1'b0, drive_seq_pkg::READY_TO_SWITCH_ON_STATE);
        rd(drive_seq_pkg::STATUS_ADDR, {24'h00, 2'b10, drive_seq_pkg::READY_TO_SWITCH_ON_STATE});
        rd(drive_seq_pkg::RAMP_QUICK_ADDR, {16'h0000, drive_seq_pkg::RAMP_QUICK_RESET});
        cmd(5'h01, 40);
        chk(1'b1, drive_seq_pkg::MOTOR_RUNNING_STATE);
        cmd(5'h00, 2);
        chk(1'b1, drive_seq_pkg::NORMAL_STOP_STATE);
        leave();
        chk(1'b0, drive_seq_pkg::READY_TO_SWITCH_ON_STATE);
        cmd(5'h01, 40);
        cmd(5'h05, 2);
        chk(1'b1, drive_seq_pkg::QUICK_STOP_STATE);
        leave();
        chk(1'b0, drive_seq_pkg::SWITCH_ON_INHIBITED_STATE);
        cmd(5'h01, 4);
        chk(1'b0, drive_seq_pkg::SWITCH_ON_INHIBITED_STATE);
        cmd(5'h00, 4);
        cmd(5'h11, 4);
        chk(1'b0, drive_seq_pkg::READY_AWAITING_ENABLE_STATE);
        cmd(5'h19, 40);
        cmd(5'h1F, 2);
        chk(1'b0, drive_seq_pkg::SWITCH_ON_INHIBITED_STATE);
        test_done();
    end
endmodule : drive_on_off_sequencer_tb
